// file: rtl/frc_top.sv
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// [R1] control register read/write, bit six read-only
// [R2] bit seven picks interrupt pin edge
// [R3] enable flag set by eni/return_from_irq_instr, cleared by disable_irq_instr or interrupt accept
// [R4] bit five picks instruction clock or pin
// [R5] bit four picks count pin edge
// [R6] prescaler off gives one count per event
// [R7] ratio code gives divide by two^(code+1)
// [R8] timeout after 256 minus loaded count
// [R9] counter clock from main or sub oscillator
// [R10] clock select: zero sub, one main default
// [R11] eight-bit up-counter wraps, sets overflow flag
// [R12] pins synchronised, one event per edge
module frc_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // oscillator enables, one-cycle pulses
  input wire logic main_osc_tick_in,
  input wire logic sub_osc_tick_in,
  // pins
  input wire logic count_pin_in,
  input wire logic ext_irq_pin_in,
  // core interrupt accept pulse
  input wire logic irq_accept_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // events
  output logic overflow_out,
  output logic ext_irq_out,
  output logic gie_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1;
  logic rst_n;
  // reset released through two flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl;
  logic [7:0] count;
  logic [7:0] sysctl;
  logic gie;
  logic ovf_flag;
  logic ext_flag;
  logic [7:0] pre_cnt;
  logic [1:0] ic_cnt;
  logic [31:0] rdata;
  logic ph_wr;
  logic ph_rd;
  logic [7:0] ph_addr;
  logic [7:0] next_ctrl;
  logic [7:0] next_count;
  logic [7:0] next_sysctl;
  logic next_gie;
  logic next_ovf_flag;
  logic next_ext_flag;
  logic [7:0] next_pre_cnt;
  logic [1:0] next_ic_cnt;
  logic [31:0] next_rdata;
  logic next_ph_wr;
  logic next_ph_rd;
  logic [7:0] next_ph_addr;
  logic tick;
  logic ic_tick;
  logic pin_ev;
  logic irq_ev;
  logic src_ev;
  logic [7:0] pre_mask;
  logic adv;
  logic wr_ctrl;
  logic wr_count;
  logic wr_sys;
  logic wr_cmd;
  logic wr_status;
  logic addr_ok;

  // counter clock chosen by system control bit
  assign tick = sysctl[frc_pkg::CLK_SEL_BIT] ? main_osc_tick_in : sub_osc_tick_in; // see [R9]
  // instruction cycle divides the counter clock
  assign ic_tick = tick && (ic_cnt == frc_pkg::INSTR_CYC_DIV);

  frc_edge_det u_cnt_edge (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .en_in(tick),
    .pin_in(count_pin_in),
    .falling_in(ctrl[frc_pkg::CNT_EDGE_BIT]), // see [R5]
    .event_out(pin_ev)
  );

  frc_edge_det u_irq_edge (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .en_in(tick),
    .pin_in(ext_irq_pin_in),
    .falling_in(ctrl[frc_pkg::IRQ_EDGE_BIT]), // see [R2]
    .event_out(irq_ev)
  );

  // source select: pin edges or instruction cycles
  assign src_ev = ctrl[frc_pkg::SRC_BIT] ? pin_ev : ic_tick; // see [R4]
  // mask of 2^(code+1)-1; all masked prescaler bits set marks the last event
  assign pre_mask = 8'((9'h2 << ctrl[2:0]) - 9'h1); // see [R7]
  assign adv = src_ev && (!ctrl[frc_pkg::PRE_EN_BIT] || ((pre_cnt & pre_mask) == pre_mask)); // see [R6]

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: writes land in the data phase
  assign addr_ok = (ph_addr == frc_pkg::CTRL_OFF) || (ph_addr == frc_pkg::COUNT_OFF) ||
                   (ph_addr == frc_pkg::SYSCTL_OFF) || (ph_addr == frc_pkg::STATUS_OFF) ||
                   (ph_addr == frc_pkg::CMD_OFF);
  assign wr_ctrl = ph_wr && (ph_addr == frc_pkg::CTRL_OFF);
  assign wr_count = ph_wr && (ph_addr == frc_pkg::COUNT_OFF);
  assign wr_sys = ph_wr && (ph_addr == frc_pkg::SYSCTL_OFF);
  assign wr_status = ph_wr && (ph_addr == frc_pkg::STATUS_OFF);
  assign wr_cmd = ph_wr && (ph_addr == frc_pkg::CMD_OFF);

  // next state of registers and counter
  always_comb begin
    next_ph_wr = hsel_in && hready_in && htrans_in[1] && hwrite_in;
    next_ph_rd = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
    next_ph_addr = (hsel_in && hready_in) ? haddr_in[7:0] : ph_addr;
    next_ic_cnt = tick ? ic_cnt + 2'h1 : ic_cnt;
    next_pre_cnt = src_ev ? pre_cnt + 8'h1 : pre_cnt;
    // bit six is kept out of software writes
    next_ctrl = wr_ctrl ? {hwdata_in[7], 1'b0, hwdata_in[5:0]} : ctrl; // see [R1]
    next_sysctl = wr_sys ? {1'b0, hwdata_in[6], 6'h00} : sysctl; // see [R10]
    // wraps 255 to 0 after 256 - load advances
    next_count = adv ? count + 8'h1 : count; // see [R8] see [R11]
    if (wr_count) begin
      next_count = hwdata_in[7:0];
      next_pre_cnt = 8'h00;
    end
    if (wr_ctrl) begin
      next_pre_cnt = 8'h00;
    end
    // accept clears, command bits set or clear; accept has priority
    next_gie = gie;
    if (wr_cmd && (hwdata_in[frc_pkg::CMD_ENI_BIT] || hwdata_in[frc_pkg::CMD_RETURN_FROM_IRQ_INSTR_BIT])) begin
      next_gie = 1'b1; // see [R3]
    end
    if ((wr_cmd && hwdata_in[frc_pkg::CMD_DISABLE_IRQ_INSTR_BIT]) || irq_accept_in) begin
      next_gie = 1'b0; // see [R3]
    end
    // write-one-to-clear, a new event beats the clear
    next_ovf_flag = (ovf_flag && !(wr_status && hwdata_in[frc_pkg::ST_OVF_BIT])) ||
                    (adv && count == 8'hff); // see [R11]
    next_ext_flag = (ext_flag && !(wr_status && hwdata_in[frc_pkg::ST_EXT_BIT])) || irq_ev;
    next_rdata = 32'h0;
    if (next_ph_rd) begin
      unique case (haddr_in[7:0])
        frc_pkg::CTRL_OFF: next_rdata = {24'h0, ctrl[7], gie, ctrl[5:0]}; // see [R1]
        frc_pkg::COUNT_OFF: next_rdata = {24'h0, count};
        frc_pkg::SYSCTL_OFF: next_rdata = {24'h0, sysctl};
        frc_pkg::STATUS_OFF: next_rdata = {30'h0, ext_flag, ovf_flag};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= frc_pkg::CTRL_RST;
      count <= frc_pkg::COUNT_RST;
      sysctl <= frc_pkg::SYSCTL_RST;
      gie <= 1'b0;
      ovf_flag <= 1'b0;
      ext_flag <= 1'b0;
      pre_cnt <= 8'h00;
      ic_cnt <= 2'h0;
      rdata <= 32'h0;
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      count <= next_count;
      sysctl <= next_sysctl;
      gie <= next_gie;
      ovf_flag <= next_ovf_flag;
      ext_flag <= next_ext_flag;
      pre_cnt <= next_pre_cnt;
      ic_cnt <= next_ic_cnt;
      rdata <= next_rdata;
      ph_wr <= next_ph_wr;
      ph_rd <= next_ph_rd;
      ph_addr <= next_ph_addr;
    end
  end

  // zero-wait slave, always okay
  assign hrdata_out = rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign overflow_out = ovf_flag;
  assign ext_irq_out = ext_flag;
  assign gie_out = gie;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  gie_ro_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R1]
    wr_ctrl && !wr_cmd && !irq_accept_in |=> gie == $past(gie))
    else $error("control write changed enable flag");
  gie_clr_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R3]
    irq_accept_in |=> !gie)
    else $error("enable flag not cleared on accept");
  gie_set_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R3]
    wr_cmd && hwdata_in[0] && !hwdata_in[1] && !irq_accept_in |=> gie)
    else $error("enable flag not set");
  no_pre_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R6]
    src_ev && !ctrl[3] && !wr_count |=> count == $past(count) + 8'h1)
    else $error("unprescaled source did not advance");
  pre_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R7]
    src_ev && ctrl[3] && pre_cnt[0] == 1'b0 && !wr_count |=> count == $past(count))
    else $error("prescaler let an early event through");
  wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R11]
    adv && count == 8'hff && !wr_count |=> count == 8'h00 && ovf_flag)
    else $error("wrap did not set overflow");
  src_sel_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R4]
    ctrl[5] && !pin_ev |-> !adv)
    else $error("counted without pin edge");
  clk_sel_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R9]
    !sysctl[6] && !sub_osc_tick_in |-> !pin_ev && !irq_ev)
    else $error("edge seen without selected tick");
  unmap_rd_a: assert property (@(posedge clk_in) disable iff (!rst_n) // see [R1]
    ph_rd && !addr_ok |-> hrdata_out == 32'h0)
    else $error("unmapped read returned data");
endmodule : frc_top

// file: rtl/frc_pkg.sv
package frc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] COUNT_OFF = 8'h04;
  localparam logic [7:0] SYSCTL_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] CMD_OFF = 8'h10;
  // control register field positions
  localparam int IRQ_EDGE_BIT = 7;
  localparam int GIE_BIT = 6;
  localparam int SRC_BIT = 5;
  localparam int CNT_EDGE_BIT = 4;
  localparam int PRE_EN_BIT = 3;
  // system control field position
  localparam int CLK_SEL_BIT = 6;
  // command register bits
  localparam int CMD_ENI_BIT = 0;
  localparam int CMD_DISABLE_IRQ_INSTR_BIT = 1;
  localparam int CMD_RETURN_FROM_IRQ_INSTR_BIT = 2;
  // status register bits
  localparam int ST_OVF_BIT = 0;
  localparam int ST_EXT_BIT = 1;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] SYSCTL_RST = 8'h40;
  // instruction cycle ends when ic_cnt reaches this, so it lasts four ticks
  localparam logic [1:0] INSTR_CYC_DIV = 2'h3;
endpackage : frc_pkg

// file: rtl/frc_edge_det.sv
`timescale 1ns/100ps
// two-stage synchroniser with edge select, advanced only on clock enable
module frc_edge_det (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  // pin and edge choice
  input wire logic pin_in,
  input wire logic falling_in,
  // result
  output logic event_out
);
  logic sync1;
  logic sync2;
  logic prev;
  logic next_sync1;
  logic next_sync2;
  logic next_prev;

  // first stage only feeds second stage
  always_comb begin
    next_sync1 = en_in ? pin_in : sync1;
    next_sync2 = en_in ? sync1 : sync2;
    next_prev = en_in ? sync2 : prev;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  // one event per selected edge
  assign event_out = en_in && (falling_in ? (prev && !sync2) : (!prev && sync2)); // see [R12]
endmodule : frc_edge_det

// file: verification/frc_pin_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// far side: count pin idles low between pulses, interrupt pin holds the level it was last given
module frc_pin_model (
  // clock
  input wire logic clk_in,
  // pins
  output logic count_pin_out,
  output logic ext_irq_pin_out
);
  // pins start at their idle level
  initial begin
    count_pin_out = 1'b0;
    ext_irq_pin_out = 1'b0;
  end
  // six-cycle phases so a slow tick still sees each level
  task automatic pulse_cnt(input int n);
    repeat (n) begin
      count_pin_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      count_pin_out <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
  endtask : pulse_cnt
  // interrupt pin is a level; the caller chooses the edge direction
  task automatic irq_level(input logic lvl);
    ext_irq_pin_out <= lvl;
    repeat (8) @(posedge clk_in);
  endtask : irq_level
endmodule : frc_pin_model

// file: verification/free_run_counter_control_bench.sv
`timescale 1ns/100ps
// bus and pin driver; a watcher checks each read against the oldest note
module free_run_counter_control_bench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sub_run = 1'b1;
  logic sub_tick = 1'b0;
  logic main_tick = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic hresp;
  logic resp_got;
  logic irq_accept = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata_out, rd_got, v;
  logic hreadyout_out, overflow_out, ext_irq_out, gie_out, count_pin, irq_pin;
  logic [31:0] exp_q[$];
  event rd_ev;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 clk_in = ~clk_in;
  // sub oscillator ticks at random while it runs
  always @(posedge clk_in) sub_tick <= sub_run && ($urandom() % 2 == 1);
  // main oscillator ticks every other clock, so ticks really are enables
  always @(posedge clk_in) main_tick <= ~main_tick;
  frc_pin_model pin_u (.clk_in(clk_in), .count_pin_out(count_pin), .ext_irq_pin_out(irq_pin));
  frc_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .main_osc_tick_in(main_tick),
    .sub_osc_tick_in(sub_tick), .count_pin_in(count_pin), .ext_irq_pin_in(irq_pin),
    .irq_accept_in(irq_accept), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp),
    .overflow_out(overflow_out), .ext_irq_out(ext_irq_out), .gie_out(gie_out));
  ////////////////////////////////////////////////////////////////////////////////
  // comparisons and the single exit
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask : cmp_bit
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // hang guard: the whole run needs about 13000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      complete_run();
    end
  end
  // watcher pairs each finished read with its note
  always begin
    @(rd_ev);
    cmp_word(rd_got, exp_q.pop_front());
    cmp_bit(resp_got, 1'b0);
  end
  ////////////////////////////////////////////////////////////////////////////////
  // single word transfer; holds each phase until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    hsel <= 1'b1;
    haddr <= {24'h0, addr};
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= data;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd_got = hrdata_out;
    resp_got = hresp;
  endtask : bus
  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, addr, 32'h0);
    ->rd_ev;
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(77));
    idle(8);
    rst_n_in <= 1'b1;
    idle(3);
    rd_chk(frc_pkg::CTRL_OFF, 32'h0);
    rd_chk(frc_pkg::SYSCTL_OFF, 32'h40);
    rd_chk(8'h14, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = {24'h0, 8'($urandom()) | 8'h40};
      bus(1'b1, frc_pkg::CTRL_OFF, v);
      rd_chk(frc_pkg::CTRL_OFF, v & 32'hbf);
    end
    // eni, disable_irq_instr, return_from_irq_instr, then a hardware accept clears the flag
    bus(1'b1, frc_pkg::CTRL_OFF, 32'h20);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, frc_pkg::CMD_OFF, 32'h1 << i);
      rd_chk(frc_pkg::CTRL_OFF, (i == 1) ? 32'h20 : 32'h60);
      cmp_bit(gie_out, i != 1);
    end
    irq_accept <= 1'b1;
    idle(1);
    irq_accept <= 1'b0;
    idle(2);
    cmp_bit(gie_out, 1'b0);
    // external rising and falling edges, then every prescale code
    bus(1'b1, frc_pkg::COUNT_OFF, 32'h0);
    pin_u.pulse_cnt(5);
    rd_chk(frc_pkg::COUNT_OFF, 32'h5);
    bus(1'b1, frc_pkg::CTRL_OFF, 32'h37);
    pin_u.pulse_cnt(3);
    rd_chk(frc_pkg::COUNT_OFF, 32'h8);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, frc_pkg::CTRL_OFF, 32'h28 | k);
      bus(1'b1, frc_pkg::COUNT_OFF, 32'h0);
      pin_u.pulse_cnt((2 << k) * 2 + 1);
      rd_chk(frc_pkg::COUNT_OFF, 32'h2);
    end
    // wrap from a loaded count: 256 - 0xfd = 3 events
    bus(1'b1, frc_pkg::CTRL_OFF, 32'h20);
    bus(1'b1, frc_pkg::COUNT_OFF, 32'hfd);
    pin_u.pulse_cnt(3);
    rd_chk(frc_pkg::COUNT_OFF, 32'h0);
    rd_chk(frc_pkg::STATUS_OFF, 32'h1);
    cmp_bit(overflow_out, 1'b1);
    bus(1'b1, frc_pkg::STATUS_OFF, 32'h1);
    rd_chk(frc_pkg::STATUS_OFF, 32'h0);
    // interrupt pin edge choice; the wrong edge must not set the flag
    pin_u.irq_level(1'b1);
    cmp_bit(ext_irq_out, 1'b1);
    pin_u.irq_level(1'b0);
    bus(1'b1, frc_pkg::STATUS_OFF, 32'h2);
    bus(1'b1, frc_pkg::CTRL_OFF, 32'ha0);
    pin_u.irq_level(1'b1);
    cmp_bit(ext_irq_out, 1'b0);
    pin_u.irq_level(1'b0);
    rd_chk(frc_pkg::STATUS_OFF, 32'h2);
    // stopped sub oscillator selected: pin edges must not count
    sub_run <= 1'b0;
    bus(1'b1, frc_pkg::SYSCTL_OFF, 32'h0);
    bus(1'b1, frc_pkg::COUNT_OFF, 32'h10);
    pin_u.pulse_cnt(3);
    rd_chk(frc_pkg::COUNT_OFF, 32'h10);
    sub_run <= 1'b1;
    bus(1'b1, frc_pkg::SYSCTL_OFF, 32'h40);
    // internal source: one count per four main ticks, 200 ticks in 400 clocks
    bus(1'b1, frc_pkg::CTRL_OFF, 32'h0);
    bus(1'b1, frc_pkg::COUNT_OFF, 32'h0);
    idle(400);
    rd_chk(frc_pkg::COUNT_OFF, 32'h32);
    // reset in mid-run brings the registers back to their reset values
    rst_n_in <= 1'b0;
    idle(2);
    rst_n_in <= 1'b1;
    idle(3);
    rd_chk(frc_pkg::CTRL_OFF, 32'h0);
    rd_chk(frc_pkg::SYSCTL_OFF, 32'h40);
    rd_chk(frc_pkg::STATUS_OFF, 32'h0);
    idle(2);
    complete_run();
  end
endmodule : free_run_counter_control_bench
